// ---- verilog/dmi_done_irq.sv ----
// Completion-interrupt controller: sticky raw status, mask with set/clear
// ports, acknowledge port, masked status and one level interrupt.
// Assumes an AXI4-Lite master on clk and event pulses synchronous to clk.
//
// The AXI4-Lite slave port was decided locally.
module dmi_done_irq
   import dmi_pkg::*;
#(
   parameter int ADDR_W = 32
)
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // completion event pulses
   input  wire dmi_pkg::dmi_done_t doneEvents,
   output      logic              irqOut,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   import dmi_pkg::*;

   if (ADDR_W < REG_ADDR_W)
   begin : g_addr_check
      $error("dmi_done_irq: ADDR_W must cover the register offsets");
   end

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   dmi_state_t        st_reg;
   dmi_state_t        st_next;
   logic [IRQ_W-1:0]  maskReg;
   logic [IRQ_W-1:0]  eventVec;
   logic [IRQ_W-1:0]  wrBits;
   logic [IRQ_W-1:0]  ackBits;
   logic [IRQ_W-1:0]  maskedSts;
   logic              doWrite;
   dmi_sel_t          wrSel;
   dmi_sel_t          rdSel;
   logic              maskWrEn;
   logic              maskSetEn;
   logic              maskClrEn;

   // protection bits carry no meaning for this block
   logic              unusedProt;
   assign unusedProt = ^{s_axi_awprot, s_axi_arprot};

   // -----------------------------------------------------------------
   // event mapping and status views
   // -----------------------------------------------------------------
   // the packed layout puts converter channels at 15..12 and the single
   // sources at 11..8 and 3..0; reserved inputs are dropped
   assign eventVec  = IRQ_W'(doneEvents) & IMPL_BITS;
   assign maskedSts = st_reg.rawSts & ~maskReg & IMPL_BITS;
   assign irqOut    = |maskedSts;

   // -----------------------------------------------------------------
   // bus handshakes
   // -----------------------------------------------------------------
   // one write at a time: address and data are each refused while it is
   // held or while the response is still waiting for bready
   assign s_axi_awready = !st_reg.awHeld && !st_reg.bValid;
   assign s_axi_wready  = !st_reg.wHeld && !st_reg.bValid;
   assign s_axi_arready = !st_reg.rValid;
   assign s_axi_bvalid  = st_reg.bValid;
   assign s_axi_bresp   = st_reg.bResp;
   assign s_axi_rvalid  = st_reg.rValid;
   assign s_axi_rdata   = st_reg.rData;
   assign s_axi_rresp   = st_reg.rResp;

   // -----------------------------------------------------------------
   // write decode
   // -----------------------------------------------------------------
   assign doWrite   = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
   assign wrSel     = dmi_decode(st_reg.awAddr);
   assign wrBits    = dmi_strobed(st_reg.wData, st_reg.wStrb);
   assign maskWrEn  = doWrite && (wrSel == SEL_MASK_REG);
   assign maskSetEn = doWrite && (wrSel == SEL_MASK_SET);
   assign maskClrEn = doWrite && (wrSel == SEL_MASK_CLR);
   assign ackBits   = (doWrite && (wrSel == SEL_ACK)) ? wrBits : STS_RESET;
   assign rdSel     = dmi_decode(s_axi_araddr[REG_ADDR_W-1:0]);

   // -----------------------------------------------------------------
   // mask register
   // -----------------------------------------------------------------
   // the same bit positions serve the set and clear ports, so channel
   // bits 15..12 line up on both without any remapping
   dmi_mask_bits #(
      .WIDTH   (IRQ_W)
   ) u_mask (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wrEn    (maskWrEn),
      .setEn   (maskSetEn),
      .clrEn   (maskClrEn),
      .wrBits  (wrBits),
      .maskReg (maskReg)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      // write channel capture, in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         st_next.awHeld = 1'b1;
         st_next.awAddr = s_axi_awaddr[REG_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         st_next.wHeld = 1'b1;
         st_next.wData = s_axi_wdata;
         st_next.wStrb = s_axi_wstrb;
      end
      if (st_reg.bValid && s_axi_bready)
      begin
         st_next.bValid = 1'b0;
      end
      if (doWrite)
      begin
         st_next.awHeld = 1'b0;
         st_next.wHeld  = 1'b0;
         st_next.bValid = 1'b1;
         st_next.bResp  = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      // a new event beats an acknowledge of the same bit in one cycle
      st_next.rawSts = ((st_reg.rawSts & ~ackBits) | eventVec) & IMPL_BITS;
      // read channel
      if (st_reg.rValid && s_axi_rready)
      begin
         st_next.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         st_next.rValid = 1'b1;
         st_next.rResp  = RESP_OKAY;
         case (rdSel)
            SEL_MASK_REG: st_next.rData = {16'h0000, maskReg};
            SEL_MASK_SET: st_next.rData = {16'h0000, PORT_RESET};
            SEL_MASK_CLR: st_next.rData = {16'h0000, PORT_RESET};
            SEL_ACK:      st_next.rData = {16'h0000, PORT_RESET};
            SEL_MASKED:   st_next.rData = {16'h0000, maskedSts};
            SEL_RAW:      st_next.rData = {16'h0000, st_reg.rawSts};
            default:
            begin
               st_next.rData = 32'h0000_0000;
               st_next.rResp = RESP_SLVERR;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg.awHeld <= 1'b0;
         st_reg.awAddr <= 8'h00;
         st_reg.wHeld  <= 1'b0;
         st_reg.wData  <= 32'h0000_0000;
         st_reg.wStrb  <= 4'h0;
         st_reg.bValid <= 1'b0;
         st_reg.bResp  <= RESP_OKAY;
         st_reg.rValid <= 1'b0;
         st_reg.rData  <= 32'h0000_0000;
         st_reg.rResp  <= RESP_OKAY;
         st_reg.rawSts <= STS_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_set_port_reads_zero;
      @(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready &&
       (s_axi_araddr[REG_ADDR_W-1:0] == OFF_MASK_SET))
      |=> (s_axi_rvalid && (s_axi_rdata == 32'h0000_0000) && (s_axi_rresp == RESP_OKAY));
   endproperty
   a_set_port_reads_zero: assert property (p_set_port_reads_zero)
      else $error("mask set port did not read as zero");

   property p_clr_port_reads_zero;
      @(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready &&
       (s_axi_araddr[REG_ADDR_W-1:0] == OFF_MASK_CLR))
      |=> (s_axi_rvalid && (s_axi_rdata == 32'h0000_0000) && (s_axi_rresp == RESP_OKAY));
   endproperty
   a_clr_port_reads_zero: assert property (p_clr_port_reads_zero)
      else $error("mask clear port did not read as zero");

   property p_set_channel6;
      @(posedge clk) disable iff (sys_rst)
      (maskSetEn && (st_reg.wStrb[1]) && st_reg.wData[15]) |=> maskReg[15];
   endproperty
   a_set_channel6: assert property (p_set_channel6)
      else $error("set of converter channel 6 did not reach bit 15");

   property p_clr_channel0;
      @(posedge clk) disable iff (sys_rst)
      (maskClrEn && (st_reg.wStrb[1]) && st_reg.wData[BIT_CONV_CH0]) |=> !maskReg[BIT_CONV_CH0];
   endproperty
   a_clr_channel0: assert property (p_clr_channel0)
      else $error("clear of converter channel 0 did not reach bit 12");

   property p_set_keeps_zeros;
      @(posedge clk) disable iff (sys_rst)
      maskSetEn |=> (maskReg == ($past(maskReg) | $past(wrBits)));
   endproperty
   a_set_keeps_zeros: assert property (p_set_keeps_zeros)
      else $error("mask set port changed bits it should have kept");

   property p_clr_keeps_zeros;
      @(posedge clk) disable iff (sys_rst)
      maskClrEn |=> (maskReg == ($past(maskReg) & ~$past(wrBits)));
   endproperty
   a_clr_keeps_zeros: assert property (p_clr_keeps_zeros)
      else $error("mask clear port changed bits it should have kept");

   property p_audio_write_bit;
      @(posedge clk) disable iff (sys_rst)
      doneEvents.audioPortWriteDone |=> st_reg.rawSts[BIT_AUDIO_WR];
   endproperty
   a_audio_write_bit: assert property (p_audio_write_bit)
      else $error("audio write completion did not set status bit 11");

   property p_mask_reset_value;
      @(posedge clk)
      $fell(sys_rst) |-> ((maskReg == MASK_RESET) && !irqOut && !s_axi_bvalid);
   endproperty
   a_mask_reset_value: assert property (p_mask_reset_value)
      else $error("mask register left reset with a wrong value");

   property p_unmasked_raises_irq;
      @(posedge clk) disable iff (sys_rst)
      (|(eventVec & ~maskReg)) && !maskWrEn && !maskSetEn |=> irqOut;
   endproperty
   a_unmasked_raises_irq: assert property (p_unmasked_raises_irq)
      else $error("unmasked completion did not raise the interrupt");

   property p_masked_stays_quiet;
      @(posedge clk) disable iff (sys_rst)
      (maskReg == IMPL_BITS) && !maskWrEn && !maskClrEn |=> !irqOut;
   endproperty
   a_masked_stays_quiet: assert property (p_masked_stays_quiet)
      else $error("interrupt raised while every source was masked");

   property p_masked_read_harmless;
      @(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready &&
       (s_axi_araddr[REG_ADDR_W-1:0] == OFF_MASKED) && (eventVec == STS_RESET) && !doWrite)
      |=> ($stable(st_reg.rawSts) &&
           (s_axi_rdata[15:0] == ($past(st_reg.rawSts) & ~$past(maskReg) & IMPL_BITS)));
   endproperty
   a_masked_read_harmless: assert property (p_masked_read_harmless)
      else $error("masked status read was wrong or changed the status");

   property p_write_answer;
      @(posedge clk) disable iff (sys_rst)
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> ##1 s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write response did not follow two cycles after address and data");

   property p_set_channel0;
      @(posedge clk) disable iff (sys_rst)
      (maskSetEn && st_reg.wStrb[1] && st_reg.wData[BIT_CONV_CH0]) |=> maskReg[BIT_CONV_CH0];
   endproperty
   a_set_channel0: assert property (p_set_channel0)
      else $error("set of converter channel 0 did not reach bit 12");

   property p_clr_channel6;
      @(posedge clk) disable iff (sys_rst)
      (maskClrEn && st_reg.wStrb[1] && st_reg.wData[15]) |=> !maskReg[15];
   endproperty
   a_clr_channel6: assert property (p_clr_channel6)
      else $error("clear of converter channel 6 did not reach bit 15");

   property p_set_write_okay;
      @(posedge clk) disable iff (sys_rst)
      maskSetEn |=> (s_axi_bvalid && (s_axi_bresp == RESP_OKAY));
   endproperty
   a_set_write_okay: assert property (p_set_write_okay)
      else $error("write to the mask set port was not answered okay");

   property p_clr_write_okay;
      @(posedge clk) disable iff (sys_rst)
      maskClrEn |=> (s_axi_bvalid && (s_axi_bresp == RESP_OKAY));
   endproperty
   a_clr_write_okay: assert property (p_clr_write_okay)
      else $error("write to the mask clear port was not answered okay");

   // reserved positions must never turn into mask bits, whatever software writes
   property p_reserved_stay_clear;
      @(posedge clk) disable iff (sys_rst)
      (maskSetEn && (st_reg.wData[7:4] != 4'h0)) |=> (maskReg[7:4] == 4'h0);
   endproperty
   a_reserved_stay_clear: assert property (p_reserved_stay_clear)
      else $error("set of a reserved bit reached the mask register");

   property p_masked_event_quiet;
      @(posedge clk) disable iff (sys_rst)
      (!irqOut && ((eventVec & ~maskReg) == STS_RESET) && !maskWrEn && !maskClrEn)
      |=> !irqOut;
   endproperty
   a_masked_event_quiet: assert property (p_masked_event_quiet)
      else $error("completion on a masked source raised the interrupt");

endmodule : dmi_done_irq

// ---- shared/dmi_pkg.sv ----
// Package for the completion-interrupt mask block: offsets, layouts,
// reset values, decode helpers and the state carrier types.
// Assumes a 32-bit AXI4-Lite register bus, of which the low 8 address bits are decoded.
package dmi_pkg;

   // -----------------------------------------------------------------
   // register map (byte offsets)
   // -----------------------------------------------------------------
   localparam int         REG_ADDR_W   = 8;
   localparam logic [7:0] OFF_MASK_REG = 8'h8c;
   localparam logic [7:0] OFF_MASK_SET = 8'h90;
   localparam logic [7:0] OFF_MASK_CLR = 8'h94;
   localparam logic [7:0] OFF_ACK      = 8'h9c;
   localparam logic [7:0] OFF_MASKED   = 8'ha0;
   localparam logic [7:0] OFF_RAW      = 8'ha4;

   // -----------------------------------------------------------------
   // field layout and reset values
   // -----------------------------------------------------------------
   localparam int          IRQ_W        = 16;
   localparam logic [15:0] IMPL_BITS    = 16'hff0f;
   localparam logic [15:0] MASK_RESET   = 16'hff0f;
   localparam logic [15:0] PORT_RESET   = 16'h0000;
   localparam logic [15:0] STS_RESET    = 16'h0000;
   localparam int          BIT_CONV_CH0 = 12;
   localparam int          BIT_AUDIO_WR = 11;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   // completion events, packed so that a cast gives the register layout
   typedef struct packed {
      logic [3:0] converterChannelDone;   // 15: ch6, 14: ch4, 13: ch2, 12: ch0
      logic       audioPortWriteDone;
      logic       audioPortReadDone;
      logic       cameraFifoEmptyDone;
      logic       cameraThresholdDone;
      logic [3:0] reserved;
      logic       serialPeriphWriteDone;
      logic       serialPeriphReadDone;
      logic       cardHostWriteDone;
      logic       cardHostReadDone;
   } dmi_done_t;

   typedef enum logic [2:0] {
      SEL_NONE     = 3'b000,
      SEL_MASK_REG = 3'b001,
      SEL_MASK_SET = 3'b010,
      SEL_MASK_CLR = 3'b011,
      SEL_ACK      = 3'b100,
      SEL_MASKED   = 3'b101,
      SEL_RAW      = 3'b110
   } dmi_sel_t;

   typedef struct packed {
      logic                  awHeld;
      logic [REG_ADDR_W-1:0] awAddr;
      logic                  wHeld;
      logic [31:0]           wData;
      logic [3:0]            wStrb;
      logic                  bValid;
      logic [1:0]            bResp;
      logic                  rValid;
      logic [31:0]           rData;
      logic [1:0]            rResp;
      logic [IRQ_W-1:0]      rawSts;
   } dmi_state_t;

   typedef struct packed {
      logic [IRQ_W-1:0] mask;
   } dmi_mask_state_t;

   function automatic dmi_sel_t dmi_decode(input logic [REG_ADDR_W-1:0] addr);
      dmi_sel_t sel;
      sel = SEL_NONE;
      case ({addr[REG_ADDR_W-1:2], 2'b00})
         OFF_MASK_REG: sel = SEL_MASK_REG;
         OFF_MASK_SET: sel = SEL_MASK_SET;
         OFF_MASK_CLR: sel = SEL_MASK_CLR;
         OFF_ACK:      sel = SEL_ACK;
         OFF_MASKED:   sel = SEL_MASKED;
         OFF_RAW:      sel = SEL_RAW;
         default:      sel = SEL_NONE;
      endcase
      return sel;
   endfunction : dmi_decode

   // bytes that were not strobed count as zeros, so on the set and clear ports they neither set nor clear
   function automatic logic [IRQ_W-1:0] dmi_strobed(input logic [31:0] data,
                                                    input logic [3:0]  strb);
      logic [31:0] keep;
      keep = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return IRQ_W'(data & keep) & IMPL_BITS;
   endfunction : dmi_strobed

endpackage : dmi_pkg

// ---- verilog/dmi_mask_bits.sv ----
// Mask register of the completion interrupts with write, set and clear ports.
// Assumes the three strobes are one-cycle pulses, at most one per cycle.
module dmi_mask_bits
   import dmi_pkg::*;
#(
   parameter int WIDTH = dmi_pkg::IRQ_W
)
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             wrEn,
   input  wire logic             setEn,
   input  wire logic             clrEn,
   input  wire logic [WIDTH-1:0] wrBits,
   output      logic [WIDTH-1:0] maskReg
);
   import dmi_pkg::*;

   dmi_mask_state_t st_reg;
   dmi_mask_state_t st_next;

   if (WIDTH != IRQ_W)
   begin : g_width_check
      $error("dmi_mask_bits: WIDTH must equal the interrupt bank width");
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      if (wrEn)
      begin
         st_next.mask = wrBits & IMPL_BITS;
      end
      else if (setEn)
      begin
         st_next.mask = st_reg.mask | wrBits;
      end
      else if (clrEn)
      begin
         st_next.mask = st_reg.mask & ~wrBits;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_reg.mask <= MASK_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign maskReg = st_reg.mask;

endmodule : dmi_mask_bits

// ---- tb/dmi_done_irq_tb.sv ----
// Self-checking bench for the completion-interrupt mask block.
// Assumes dmi_pkg and dmi_done_irq are compiled first; one 40 MHz clock, sync reset.
module dmi_done_irq_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dmi_pkg::*;

   logic        clk;
   logic        sys_rst;
   dmi_done_t   doneEvents;
   logic        irqOut;
   logic [31:0] s_axi_awaddr;
   logic [31:0] s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [31:0] s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  s_axi_awprot;
   logic [2:0]  s_axi_arprot;
   logic [1:0]  s_axi_bresp;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          mismatches;
   int          n_compared;
   logic [33:0] expQ[$];
   logic [15:0] maskModel;
   logic [15:0] rawModel;

   dmi_done_irq dut (
      .clk(clk), .sys_rst(sys_rst), .doneEvents(doneEvents), .irqOut(irqOut),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // --------------------------------------------------------------
   // comparison and closing
   // --------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // handshakes are judged at the falling edge: inputs and state are settled there
   always @(negedge clk)
   begin
      if (!sys_rst && s_axi_bvalid && s_axi_bready)
         check({s_axi_bresp, 32'h0}, expQ.pop_front());
      if (!sys_rst && s_axi_rvalid && s_axi_rready)
         check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
   end

   // --------------------------------------------------------------
   // bus master
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic pa, pw, pb, ta, tw, tb;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      expQ.push_back({resp, 32'h0});
      s_axi_awaddr  <= {24'h0, a};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (pa || pw || pb)
      begin
         @(negedge clk);
         ta = pa && s_axi_awready;
         tw = pw && s_axi_wready;
         tb = pb && s_axi_bvalid;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
         pb = pb && !tb;
      end
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      logic pa, pr, ta, tr;
      pa = 1'b1;
      pr = 1'b1;
      expQ.push_back(exp);
      s_axi_araddr  <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (pa || pr)
      begin
         @(negedge clk);
         ta = pa && s_axi_arready;
         tr = pr && s_axi_rvalid;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
         pa = pa && !ta;
         pr = pr && !tr;
      end
      @(posedge clk);
   endtask : rd

   task automatic setClr(input logic doSet, input logic [31:0] d);
      wr(doSet ? OFF_MASK_SET : OFF_MASK_CLR, d, RESP_OKAY);
      maskModel = doSet ? (maskModel | (d[15:0] & IMPL_BITS)) : (maskModel & ~d[15:0]);
   endtask : setClr

   task automatic pulse(input logic [15:0] v);
      doneEvents <= dmi_done_t'(v);
      rawModel = rawModel | (v & IMPL_BITS);
      @(posedge clk);
      doneEvents <= '0;
      @(posedge clk);
   endtask : pulse

   task automatic irqChk;
      @(negedge clk);
      check({33'h0, irqOut}, {33'h0, |(rawModel & ~maskModel)});
      @(posedge clk);
   endtask : irqChk

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      void'($urandom(72));
      sys_rst = 1'b1;
      doneEvents = '0;
      s_axi_awaddr = 32'h0;
      s_axi_araddr = 32'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      mismatches = 0;
      n_compared = 0;
      maskModel = 16'hff0f;
      rawModel = 16'h0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(OFF_MASK_REG, {RESP_OKAY, 32'h0000ff0f});
      rd(OFF_MASK_SET, {RESP_OKAY, 32'h0});
      rd(OFF_MASK_CLR, {RESP_OKAY, 32'h0});
      rd(OFF_MASKED, {RESP_OKAY, 32'h0});
      // walk one bit through the clear port, then through the set port
      for (int j = 0; j < 32; j++)
      begin
         setClr(j >= 16, 32'h1 << (j % 16));
         rd(OFF_MASK_REG, {RESP_OKAY, 16'h0, maskModel});
      end
      // random patterns, reserved bits included, zeros must leave bits alone
      for (int j = 0; j < 24; j++)
      begin
         r = $urandom;
         setClr(r[31], r);
         rd(OFF_MASK_REG, {RESP_OKAY, 16'h0, maskModel});
      end
      // all masked, then unmask raised sources one at a time
      setClr(1'b1, 32'hffffffff);
      r = $urandom;
      pulse(r[15:0] | 16'h8001);
      irqChk();
      rd(OFF_MASKED, {RESP_OKAY, 32'h0});
      rd(OFF_RAW, {RESP_OKAY, 16'h0, rawModel});
      for (int i = 0; i < 16; i++)
      begin
         if (rawModel[i])
         begin
            setClr(1'b0, 32'h1 << i);
            irqChk();
            rd(OFF_MASKED, {RESP_OKAY, 16'h0, rawModel & ~maskModel});
            rd(OFF_MASKED, {RESP_OKAY, 16'h0, rawModel & ~maskModel});
            setClr(1'b1, 32'h1 << i);
            irqChk();
         end
      end
      setClr(1'b0, 32'h0000ff0f);
      irqChk();
      wr(OFF_ACK, {16'h0, rawModel}, RESP_OKAY);
      rawModel = 16'h0;
      irqChk();
      // unmapped offset is refused and changes nothing
      wr(8'h80, 32'hffffffff, RESP_SLVERR);
      rd(8'h80, {RESP_SLVERR, 32'h0});
      rd(OFF_MASK_REG, {RESP_OKAY, 32'h0});
      rd(OFF_MASK_SET, {RESP_OKAY, 32'h0});
      rd(OFF_MASK_CLR, {RESP_OKAY, 32'h0});
      // direct mask write drops reserved bits; a strobed clear only touches its byte
      wr(OFF_MASK_REG, 32'hffffa5f5, RESP_OKAY);
      rd(OFF_MASK_REG, {RESP_OKAY, 32'h0000a505});
      s_axi_wstrb <= 4'h1;
      wr(OFF_MASK_CLR, 32'hffffffff, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(OFF_MASK_REG, {RESP_OKAY, 32'h0000a500});
      test_done();
   end

   // the whole run needs well under a thousand cycles; this bound cuts a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end

endmodule : dmi_done_irq_tb
